// [rtl/dtc_map.vh]
// Register map, field positions and reset values of the dual timer common control slice.
// Assumes byte-wide and 16-bit registers in word slots of an APB slave with 32-bit data.
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// Byte addresses of the control registers on APB.
`define DTC_ADDR_RUN        8'h00
`define DTC_ADDR_MODE       8'h04
`define DTC_ADDR_PWM        8'h08
`define DTC_ADDR_FUNC       8'h0C
`define DTC_ADDR_CNT0       8'h10
`define DTC_ADDR_CNT1       8'h14
`define DTC_ADDR_GR0        8'h20
`define DTC_ADDR_GR1        8'h30

// Run control fields.
`define DTC_RUN_CH0         0
`define DTC_RUN_CH1         1
`define DTC_RUN_RSV         8'hFC

// Buffer and synchronisation mode fields.
`define DTC_MODE_SYNC       0
`define DTC_MODE_BUF_C_CH0  4
`define DTC_MODE_BUF_D_CH0  5
`define DTC_MODE_BUF_C_CH1  6
`define DTC_MODE_BUF_D_CH1  7
`define DTC_MODE_RSV        8'h0E

// Pin PWM select fields and reserved mask.
`define DTC_PWM_RSV         8'h88

// Function control: combination mode field in the low two bits, reserved bit 7 reads 1.
`define DTC_FUNC_RSV        8'h80
`define DTC_CMD_NORMAL      2'h0
`define DTC_FUNC_EXTCLK     6

// Pins driven as PWM in the combined modes: pins D, C, B of channel 0 and all of channel 1.
`define DTC_COMB_CH0        4'hE
`define DTC_COMB_CH1        4'hF

// Width of the general register and counter words.
`define DTC_WORD_W          16
`define DTC_ZERO8           8'h00
`define DTC_ZERO16          16'h0000
`define DTC_ZERO32          32'h00000000

`endif

// [rtl/dtc_channel.v]
// One timer channel: a counter, four general registers and the buffer pairing.
// Assumes the parent decodes bus writes and supplies the run, preset, clear and buffer enables.
`timescale 1ns/100ps
`include "dtc_map.vh"

module dtc_channel #(
   parameter W = 16                             // Counter and general register width.
) (
   // Clock and reset.
   input  wire         mclk,
   input  wire         rst_b,
   // Control from the common registers.
   input  wire         run,                     // Counter advances while high.
   input  wire         preset,                  // Load the counter from preset_val.
   input  wire [W-1:0] preset_val,              // Value loaded on preset.
   input  wire         clear,                   // Clear the counter to zero.
   input  wire         buf_c,                   // Register C buffers register A.
   input  wire         buf_d,                   // Register D buffers register B.
   input  wire         xfer,                    // Transfer buffers into A and B.
   // General register writes.
   input  wire         gr_we,                   // Write strobe for a general register.
   input  wire [1:0]   gr_sel,                  // 0 A, 1 B, 2 C, 3 D.
   input  wire [W-1:0] gr_wdata,                // Data written.
   // State seen by the parent.
   output reg  [W-1:0] count,                   // Counter value.
   output wire [4*W-1:0] gr_flat                // General registers D, C, B, A.
);

   reg [W-1:0] gr [0:3];                        // General registers A to D, by index.

   // Counter: clear beats preset, preset beats counting, and it holds while halted.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count <= {W{1'b0}};
      end else if (clear) begin
         count <= {W{1'b0}};
      end else if (preset) begin
         count <= preset_val;
      end else if (run) begin
         count <= count + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // General registers: with buffering on, a transfer copies C into A and D into B.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         gr[0] <= {W{1'b0}};
         gr[1] <= {W{1'b0}};
         gr[2] <= {W{1'b0}};
         gr[3] <= {W{1'b0}};
      end else begin
         if (gr_we) begin
            gr[gr_sel] <= gr_wdata;
         end
         // A bus write to A or B wins over a transfer in the same cycle.
         if (xfer && buf_c && !(gr_we && gr_sel == 2'd0)) begin
            gr[0] <= gr[2];
         end
         if (xfer && buf_d && !(gr_we && gr_sel == 2'd1)) begin
            gr[1] <= gr[3];
         end
      end
   end

   // Flatten the registers for readback.
   assign gr_flat = {gr[3], gr[2], gr[1], gr[0]};

endmodule

// [rtl/dtc_top.v]
// Common control of a two-channel 16-bit timer with an APB register slave.
// Assumes an APB master on mclk; pin drivers outside resolve the enables into wires.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "dtc_map.vh"

// Contract
// - Channel 0 counts only while run bit 0
// - Channel 1 counts only while run bit 1
// - Run bits reset 0; bits 7-2 read 1
// - Mode bit 7: channel 1 D buffers B
// - Mode bit 5: channel 0 D buffers B
// - Mode bit 4: channel 0 C buffers A
// - Mode bit 6: channel 1 C buffer enable
// - Sync bit: preset and clear hit both counters
// - Sync off: counters preset and clear independently
// - Select bits 0-2 put channel 0 B-D in PWM
// - Select bits 4-6 put channel 1 B-D in PWM
// - Select bits 7,3 read 1; others reset 0
// - Channel 0 pin A: compare, capture or clock
// - Channel 0 pin C: sync PWM in combined modes
// - Channel 1 pin A: PWM in combined modes
// - Other pins: compare, capture or PWM
// - Combined mode overrides per-pin PWM selects
module dtc_top #(
   parameter W = 16                             // Counter width.
) (
   // Clock and reset.
   input  wire         mclk,
   input  wire         rst_b,
   // APB slave.
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // Channel 0 timer pins: input, output and output enable.
   input  wire [3:0]   pin_ch0_in,              // Pins D, C, B, A of channel 0.
   output reg  [3:0]   pin_ch0_out,
   output reg  [3:0]   pin_ch0_oe,
   // Channel 1 timer pins: input, output and output enable.
   input  wire [3:0]   pin_ch1_in,              // Pins D, C, B, A of channel 1.
   output reg  [3:0]   pin_ch1_out,
   output reg  [3:0]   pin_ch1_oe,
   // Per-pin function as decoded, for the waveform logic outside.
   output reg  [3:0]   pwm_mode_ch0,            // Pins D, C, B, A of channel 0 in PWM.
   output reg  [3:0]   pwm_mode_ch1,            // Pins D, C, B, A of channel 1 in PWM.
   output reg          external_count_clock     // Clock taken from channel 0 pin A.
);

   // Control registers, stored bits only; reserved bits are forced on read.
   reg  [1:0]   counter_run_control;            // Run bits of both channels.
   reg  [7:0]   buffer_and_sync_mode;           // Buffer pairing and sync bits.
   reg  [7:0]   pin_pwm_select;                 // Per-pin PWM selects.
   reg  [7:0]   function_control_reg;           // Combination mode and clock input select.
   reg  [3:0]   cmp_ch0;                        // Compare level per pin of channel 0.
   reg  [3:0]   cmp_ch1;                        // Compare level per pin of channel 1.

   // Bus decode.
   wire         wr_en   = psel && penable && pwrite;
   wire         rd_en   = psel && penable && !pwrite;
   wire         hit_gr0 = (paddr[7:4] == `DTC_ADDR_GR0 >> 4);
   wire         hit_gr1 = (paddr[7:4] == `DTC_ADDR_GR1 >> 4);
   wire         cnt0_we = wr_en && paddr == `DTC_ADDR_CNT0;
   wire         cnt1_we = wr_en && paddr == `DTC_ADDR_CNT1;
   wire [W-1:0] wval    = pwdata[W-1:0];

   // Channel state.
   wire [W-1:0]   count0;
   wire [W-1:0]   count1;
   wire [4*W-1:0] gr0;
   wire [4*W-1:0] gr1;
   wire           sync  = buffer_and_sync_mode[`DTC_MODE_SYNC];
   wire [1:0]     cmd   = function_control_reg[1:0];
   wire           comb  = (cmd != `DTC_CMD_NORMAL);

   // Preset and clear of each counter; with sync on, either one hits both.
   wire           pre0  = cnt0_we || (sync && cnt1_we);
   wire           pre1  = cnt1_we || (sync && cnt0_we);
   wire [W-1:0]   cnt_m0 = gr0[W-1:0];
   wire [W-1:0]   cnt_m1 = gr1[W-1:0];
   wire           clr0_own = counter_run_control[`DTC_RUN_CH0] && count0 == cnt_m0 && cnt_m0 != {W{1'b0}};
   wire           clr1_own = counter_run_control[`DTC_RUN_CH1] && count1 == cnt_m1 && cnt_m1 != {W{1'b0}};
   wire           clr0  = clr0_own || (sync && clr1_own);
   wire           clr1  = clr1_own || (sync && clr0_own);

   // Decode whether an address names a mapped register.
   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `DTC_ADDR_RUN) || (a == `DTC_ADDR_MODE) || (a == `DTC_ADDR_PWM) ||
                  (a == `DTC_ADDR_FUNC) || (a == `DTC_ADDR_CNT0) || (a == `DTC_ADDR_CNT1) ||
                  ((a[7:4] == `DTC_ADDR_GR0 >> 4) && a[1:0] == 2'b00) ||
                  ((a[7:4] == `DTC_ADDR_GR1 >> 4) && a[1:0] == 2'b00);
      end
   endfunction

   // Channel 0.
   dtc_channel #(
      .W          (W)
   ) u_ch0 (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .run        (counter_run_control[`DTC_RUN_CH0]),
      .preset     (pre0),
      .preset_val (wval),
      .clear      (clr0),
      .buf_c      (buffer_and_sync_mode[`DTC_MODE_BUF_C_CH0]),
      .buf_d      (buffer_and_sync_mode[`DTC_MODE_BUF_D_CH0]),
      .xfer       (clr0),
      .gr_we      (wr_en && hit_gr0),
      .gr_sel     (paddr[3:2]),
      .gr_wdata   (wval),
      .count      (count0),
      .gr_flat    (gr0)
   );

   // Channel 1.
   dtc_channel #(
      .W          (W)
   ) u_ch1 (
      .mclk       (mclk),
      .rst_b      (rst_b),
      .run        (counter_run_control[`DTC_RUN_CH1]),
      .preset     (pre1),
      .preset_val (wval),
      .clear      (clr1),
      .buf_c      (buffer_and_sync_mode[`DTC_MODE_BUF_C_CH1]),
      .buf_d      (buffer_and_sync_mode[`DTC_MODE_BUF_D_CH1]),
      .xfer       (clr1),
      .gr_we      (wr_en && hit_gr1),
      .gr_sel     (paddr[3:2]),
      .gr_wdata   (wval),
      .count      (count1),
      .gr_flat    (gr1)
   );

   // Register writes: only the low byte of the word carries a control register.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         counter_run_control  <= 2'b00;
         buffer_and_sync_mode <= `DTC_ZERO8;
         pin_pwm_select       <= `DTC_ZERO8;
         function_control_reg <= `DTC_ZERO8;
      end else if (wr_en) begin
         case (paddr)
            `DTC_ADDR_RUN: begin
               counter_run_control <= pwdata[1:0];
            end
            `DTC_ADDR_MODE: begin
               buffer_and_sync_mode <= pwdata[7:0] & ~`DTC_MODE_RSV;
            end
            `DTC_ADDR_PWM: begin
               pin_pwm_select <= pwdata[7:0] & ~`DTC_PWM_RSV;
            end
            `DTC_ADDR_FUNC: begin
               // Software is expected to halt both counters first.
               function_control_reg <= pwdata[7:0] & ~`DTC_FUNC_RSV;
            end
            default: begin
               function_control_reg <= function_control_reg;
            end
         endcase
      end
   end

   // APB answer: zero wait states, error on unmapped addresses.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `DTC_ZERO32;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped(paddr);
         prdata  <= `DTC_ZERO32;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `DTC_ADDR_RUN:  prdata <= {24'h000000, `DTC_RUN_RSV | {6'h00, counter_run_control}};
               `DTC_ADDR_MODE: prdata <= {24'h000000, buffer_and_sync_mode | `DTC_MODE_RSV};
               `DTC_ADDR_PWM:  prdata <= {24'h000000, pin_pwm_select | `DTC_PWM_RSV};
               `DTC_ADDR_FUNC: prdata <= {24'h000000, function_control_reg | `DTC_FUNC_RSV};
               `DTC_ADDR_CNT0: prdata <= {16'h0000, count0};
               `DTC_ADDR_CNT1: prdata <= {16'h0000, count1};
               default: begin
                  if (hit_gr0) begin
                     prdata <= {16'h0000, gr0[paddr[3:2]*W +: W]};
                  end else if (hit_gr1) begin
                     prdata <= {16'h0000, gr1[paddr[3:2]*W +: W]};
                  end
               end
            endcase
         end
      end
   end

   // Pin function decode: combined modes override the per-pin selects.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pwm_mode_ch0         <= 4'h0;
         pwm_mode_ch1         <= 4'h0;
         external_count_clock <= 1'b0;
      end else begin
         if (comb) begin
            pwm_mode_ch0 <= `DTC_COMB_CH0;
            pwm_mode_ch1 <= `DTC_COMB_CH1;
         end else begin
            pwm_mode_ch0 <= {pin_pwm_select[2:0], 1'b0};
            pwm_mode_ch1 <= {pin_pwm_select[6:4], 1'b0};
         end
         // Pin A of channel 0 serves as the clock input when selected.
         external_count_clock <= function_control_reg[`DTC_FUNC_EXTCLK] & pin_ch0_in[0];
      end
   end

   // Compare level per pin: high when the counter has reached the general register.
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_cmp
         always @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               cmp_ch0[g] <= 1'b0;
               cmp_ch1[g] <= 1'b0;
            end else begin
               cmp_ch0[g] <= (count0 >= gr0[g*W +: W]);
               cmp_ch1[g] <= (count1 >= gr1[g*W +: W]);
            end
         end
      end
   endgenerate

   // Pin drive: PWM pins drive; pin A of channel 0 also drives while channel 0 runs, unless selected as clock input.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pin_ch0_out <= 4'h0;
         pin_ch0_oe  <= 4'h0;
         pin_ch1_out <= 4'h0;
         pin_ch1_oe  <= 4'h0;
      end else begin
         pin_ch0_out <= cmp_ch0;
         pin_ch1_out <= cmp_ch1;
         pin_ch0_oe  <= pwm_mode_ch0 |
                        {3'b000, !function_control_reg[`DTC_FUNC_EXTCLK] & counter_run_control[`DTC_RUN_CH0]};
         pin_ch1_oe  <= pwm_mode_ch1;
      end
   end

endmodule

// [verif/dtc_top_asserts.sv]
// Concurrent checks of the timer common control, seen at the top ports only.
// Assumes it is bound into dtc_top and that the APB master keeps the protocol.
`timescale 1ns/100ps
`include "dtc_map.vh"

module dtc_chk #(
   parameter W = 16                             // Counter width, handed on by the bind.
) (
   // Clock and reset.
   input wire         mclk,
   input wire         rst_b,
   // APB slave side.
   input wire         psel,
   input wire         penable,
   input wire         pwrite,
   input wire [7:0]   paddr,
   input wire [31:0]  pwdata,
   input wire [31:0]  prdata,
   input wire         pready,
   input wire         pslverr,
   // Pin functions.
   input wire [3:0]   pin_ch0_in,
   input wire [3:0]   pwm_mode_ch0,
   input wire [3:0]   pwm_mode_ch1,
   input wire         external_count_clock
);
   reg [1:0] cmd;                               // Combination mode as last written.
   reg [7:0] sel;                               // Pin PWM selects as last written.

   // Shadows the function and select registers from completed writes.
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cmd <= 2'h0;
         sel <= 8'h00;
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == `DTC_ADDR_FUNC) cmd <= pwdata[1:0];
         if (paddr == `DTC_ADDR_PWM) sel <= pwdata[7:0];
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);

   // Setup cycle of any transfer, and of a read of one address.
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_rd(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence

   property p_ready_after_setup; s_setup |=> pready; endproperty
   property p_ready_pulse; pready |=> !pready; endproperty
   property p_err_with_ready; pslverr |-> pready; endproperty
   property p_rdata_idle; !pready |-> prdata == `DTC_ZERO32; endproperty
   property p_run_rsv; s_rd(`DTC_ADDR_RUN) |=> prdata[31:2] == 30'h0000003F; endproperty
   property p_mode_rsv; s_rd(`DTC_ADDR_MODE) |=> prdata[31:8] == 24'h0 && prdata[3:1] == 3'h7; endproperty
   property p_pwm_rsv; s_rd(`DTC_ADDR_PWM) |=> prdata[31:8] == 24'h0 && prdata[7] && prdata[3]; endproperty
   property p_pin_a0; pwm_mode_ch0[0] == 1'b0; endproperty
   property p_pwm_sel;
      (cmd == 2'h0 && $stable(cmd) && $stable(sel)) |->
         pwm_mode_ch0 == {sel[2:0], 1'b0} && pwm_mode_ch1 == {sel[6:4], 1'b0};
   endproperty
   property p_combined;
      (cmd != 2'h0 && $stable(cmd)) |-> pwm_mode_ch0 == 4'hE && pwm_mode_ch1 == 4'hF;
   endproperty
   property p_ext_clk; external_count_clock |-> $past(pin_ch0_in[0]); endproperty

   a_ready_after_setup: assert property (p_ready_after_setup) else $error("No ready after setup.");
   a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held too long.");
   a_err_with_ready: assert property (p_err_with_ready) else $error("Error without ready.");
   a_rdata_idle: assert property (p_rdata_idle) else $error("Read data outside access.");
   a_run_rsv: assert property (p_run_rsv) else $error("Run control high bits wrong.");
   a_mode_rsv: assert property (p_mode_rsv) else $error("Mode fixed bits wrong.");
   a_pwm_rsv: assert property (p_pwm_rsv) else $error("Select fixed bits wrong.");
   a_pin_a0: assert property (p_pin_a0) else $error("Channel 0 pin A in PWM.");
   a_pwm_sel: assert property (p_pwm_sel) else $error("Pin PWM function wrong.");
   a_combined: assert property (p_combined) else $error("Combined mode not applied.");
   a_ext_clk: assert property (p_ext_clk) else $error("Count clock without pin.");
endmodule

bind dtc_top dtc_chk #(.W(W)) u_chk (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pin_ch0_in(pin_ch0_in), .pwm_mode_ch0(pwm_mode_ch0),
   .pwm_mode_ch1(pwm_mode_ch1), .external_count_clock(external_count_clock));

// [verif/dtc_tb.sv]
// Self-checking bench of the timer common control over APB.
// Assumes the zero-wait APB slave and register map of dtc_map.vh.
`timescale 1ns/100ps
`include "dtc_map.vh"

module testbench;
   reg         mclk = 1'b0;                     // 200 MHz clock.
   reg         rst_b = 1'b0;                    // Reset, active low.
   reg         psel = 1'b0;                     // APB request.
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h00000000;
   reg  [3:0]  pin_ch0_in = 4'h0;               // Channel 0 pin inputs.
   reg  [3:0]  pin_ch1_in = 4'h0;               // Channel 1 pin inputs.
   wire [31:0] prdata;
   wire        pready;
   wire        pslverr;
   wire [3:0]  pwm_mode_ch0;
   wire [3:0]  pwm_mode_ch1;
   wire        external_count_clock;
   wire [3:0]  pin_ch0_out;                     // Compare levels of channel 0.
   wire [3:0]  pin_ch0_oe;                      // Drive enables of channel 0.
   wire [3:0]  pin_ch1_out;                     // Compare levels of channel 1.
   wire [3:0]  pin_ch1_oe;                      // Drive enables of channel 1.
   integer     errors = 0;                      // Mismatches seen.
   integer     checks = 0;                      // Comparisons made.
   reg  [31:0] d;                               // Last read data.
   reg         e;                               // Last error response.
   integer     i;

   dtc_top #(.W(16)) uut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_ch0_in(pin_ch0_in), .pin_ch0_out(pin_ch0_out), .pin_ch0_oe(pin_ch0_oe), .pin_ch1_in(pin_ch1_in),
      .pin_ch1_out(pin_ch1_out), .pin_ch1_oe(pin_ch1_oe), .pwm_mode_ch0(pwm_mode_ch0), .pwm_mode_ch1(pwm_mode_ch1),
      .external_count_clock(external_count_clock));

   // Clock generator.
   always #2.5 mclk = ~mclk;

   // Prints the counts and the verdict, then stops.
   task give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // Compares a word read from the bus.
   task chk32(input [31:0] got, input [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask

   // Compares a pin function nibble.
   task chkb(input [3:0] got, input [3:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[ERR] %0t pins %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the request stands until pready is seen high at a rising edge, where data is taken.
   task apb(input [7:0] a, input w, input [31:0] wd);
      integer n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors = errors + 1;
         $display("[ERR] %0t no ready", $time);
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input [7:0] a, input [15:0] v);
      apb(a, 1'b1, {16'h0000, v});
   endtask

   // Reads an address and compares it.
   task rchk(input [7:0] a, input [31:0] exp);
      apb(a, 1'b0, `DTC_ZERO32);
      chk32(d, exp);
   endtask

   // Reset values and fixed bits of the run, mode and select control registers.
   task t_regs;
      reg [7:0] fix;
      for (i = 0; i < 3; i = i + 1) begin
         fix = (i == 0) ? 8'hFC : (i == 1) ? 8'h0E : 8'h88;
         rchk(4 * i, {24'h0, fix});
         wr(4 * i, 16'h00FF);
         rchk(4 * i, 32'h000000FF);
         wr(4 * i, 16'h0000);
         rchk(4 * i, {24'h0, fix});
      end
      apb(8'h40, 1'b0, `DTC_ZERO32);
      chk32({31'h0, e}, 32'h00000001);
      chk32(d, 32'h00000000);
   endtask

   // Each counter advances only under its own run bit.
   task t_run;
      reg [31:0] c0;
      wr(`DTC_ADDR_CNT0, 16'h0000);
      wr(`DTC_ADDR_CNT1, 16'h0000);
      wr(`DTC_ADDR_RUN, 16'h0001);
      repeat (20) @(posedge mclk);
      wr(`DTC_ADDR_RUN, 16'h0000);
      apb(`DTC_ADDR_CNT0, 1'b0, `DTC_ZERO32);
      c0 = d;
      chk32({31'h0, c0 != 0}, 32'h00000001);
      rchk(`DTC_ADDR_CNT1, 32'h00000000);
      wr(`DTC_ADDR_RUN, 16'h0002);
      repeat (20) @(posedge mclk);
      wr(`DTC_ADDR_RUN, 16'h0000);
      rchk(`DTC_ADDR_CNT0, c0);
      apb(`DTC_ADDR_CNT1, 1'b0, `DTC_ZERO32);
      chk32({31'h0, d != 0}, 32'h00000001);
   endtask

   // Presets reach both counters only while synchronised.
   task t_sync;
      wr(`DTC_ADDR_MODE, 16'h0001);
      wr(`DTC_ADDR_CNT0, 16'h1234);
      rchk(`DTC_ADDR_CNT1, 32'h00001234);
      wr(`DTC_ADDR_CNT1, 16'h0ABC);
      rchk(`DTC_ADDR_CNT0, 32'h00000ABC);
      wr(`DTC_ADDR_MODE, 16'h0000);
      wr(`DTC_ADDR_CNT0, 16'h0055);
      rchk(`DTC_ADDR_CNT1, 32'h00000ABC);
      // Compare levels: only pin A of channel 0 sits below its general register.
      wr(`DTC_ADDR_GR0, 16'h0060);
      repeat (3) @(negedge mclk);
      chkb(pin_ch0_out, 4'hE);
      chkb(pin_ch1_out, 4'hF);
      // A match clear on channel 0 also clears the halted channel 1 while synchronised.
      wr(`DTC_ADDR_MODE, 16'h0001);
      wr(`DTC_ADDR_CNT0, 16'h0050);
      wr(`DTC_ADDR_RUN, 16'h0001);
      repeat (20) @(posedge mclk);
      wr(`DTC_ADDR_RUN, 16'h0000);
      rchk(`DTC_ADDR_CNT1, 32'h00000000);
   endtask

   // Buffer pairing: C feeds A and D feeds B at the match on A.
   task t_buf(input [7:0] m);
      integer c;
      reg [7:0] b;
      wr(`DTC_ADDR_MODE, {8'h00, m});
      wr(`DTC_ADDR_CNT0, 16'h0000);
      wr(`DTC_ADDR_CNT1, 16'h0000);
      for (c = 0; c < 2; c = c + 1) begin
         b = c ? `DTC_ADDR_GR1 : `DTC_ADDR_GR0;
         wr(b, 16'h0010);
         wr(b + 8'h04, 16'h0030);
         wr(b + 8'h08, 16'h0077);
         wr(b + 8'h0C, 16'h0066);
      end
      wr(`DTC_ADDR_RUN, 16'h0003);
      repeat (40) @(posedge mclk);
      wr(`DTC_ADDR_RUN, 16'h0000);
      for (c = 0; c < 2; c = c + 1) begin
         b = c ? `DTC_ADDR_GR1 : `DTC_ADDR_GR0;
         rchk(b, m[4 + 2 * c] ? 32'h77 : 32'h10);
         rchk(b + 8'h04, m[5 + 2 * c] ? 32'h66 : 32'h30);
      end
   endtask

   // Per-pin selects, the combined override and the external clock pin.
   task t_pins;
      reg [7:0] s;
      for (i = 0; i < 7; i = i + 1) begin
         s = 8'h01 << i;
         wr(`DTC_ADDR_PWM, {8'h00, s & 8'h77});
         repeat (3) @(negedge mclk);
         chkb(pwm_mode_ch0, {s[2:0], 1'b0});
         chkb(pwm_mode_ch1, {s[6:4], 1'b0});
      end
      // Both counters are halted here, so combined modes may be selected.
      for (i = 1; i < 4; i = i + 1) begin
         wr(`DTC_ADDR_FUNC, i);
         repeat (3) @(negedge mclk);
         chkb(pwm_mode_ch0, 4'hE);
         chkb(pwm_mode_ch1, 4'hF);
         chkb(pin_ch0_oe, 4'hE);
         chkb(pin_ch1_oe, 4'hF);
      end
      wr(`DTC_ADDR_FUNC, 16'h0040);
      pin_ch0_in <= 4'h1;
      repeat (3) @(negedge mclk);
      chkb({3'h0, external_count_clock}, 4'h1);
      wr(`DTC_ADDR_FUNC, 16'h0000);
      repeat (3) @(negedge mclk);
      chkb({3'h0, external_count_clock}, 4'h0);
   endtask

   // Main sequence.
   initial begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      t_regs;
      t_run;
      t_sync;
      t_buf(8'hF0);
      t_buf(8'h50);
      t_buf(8'hA0);
      t_pins;
      give_verdict;
   end

   // Watchdog well beyond the expected run length.
   initial begin
      #200000;
      errors = errors + 1;
      $display("[ERR] %0t timeout", $time);
      give_verdict;
   end
endmodule
